// >>> include/owdt_consts.svh
// constants of the operating watchdog: offsets, fields, reset values, counts
//
// Behaviour
// RQ1: every reset sets the watchdog enable bit, so the watchdog runs.
// RQ2: cleared watchdog enable stops counting; no timeout reset is produced.
// RQ3: any write to the reset cause address clears the counter only; the code also sets the service bit of the interrupt status.
// RQ4: clock select 1 counts bus clocks, 0 counts internal 1 kHz ticks.
// RQ5: timeout select picks 2^5 or 2^8 slow ticks, 2^13 or 2^18 bus clocks.
// RQ6: after reset the 1 kHz source and the long timeout are selected.
// RQ7: enabled counter reaching the selected count issues a system reset.
// RQ8: both option registers take one write after reset; later ones ignored.
// RQ9: the first write to either option register also clears the counter.
// RQ10: software must not service the watchdog from an interrupt handler.
// RQ11: in background debug mode the counter holds without incrementing.
// RQ12: on bus clock the counter freezes in stop mode, resumes after it.
// RQ13: on the 1 kHz clock stop entry zeroes the counter; restarts from zero.
// RQ14: a watchdog timeout sets the watchdog source bit of the cause register.
// RQ15: any system reset zeroes the counter; timeout reset is one pulse.
// RQ16: selections change only by the first option write, restarting at zero.
`ifndef OWDT_CONSTS_SVH
`define OWDT_CONSTS_SVH

// register byte offsets
`define OWDT_OFS_CAUSE 8'h00
`define OWDT_OFS_OPT1 8'h04
`define OWDT_OFS_OPT2 8'h08
`define OWDT_OFS_STAT 8'h0c
`define OWDT_OFS_MASK 8'h10
`define OWDT_OFS_COUNT 8'h14

// field positions
`define OWDT_OPT1_ENABLE 0
`define OWDT_OPT1_TSEL 1
`define OWDT_OPT2_CSEL 0
`define OWDT_CAUSE_POR 0
`define OWDT_CAUSE_WDOG 1
`define OWDT_CAUSE_EXT 2
`define OWDT_EV_HALF 0
`define OWDT_EV_SERVICE 1
`define OWDT_EV_REFUSED 2

// reset values
`define OWDT_RST_ENABLE 1'b1
`define OWDT_RST_TSEL 1'b1
`define OWDT_RST_CSEL 1'b0
`define OWDT_RST_CAUSE 3'h1

// timing: slow source period and timeouts in their own units
`define OWDT_SLOW_PERIOD_US 1000
`define OWDT_SLOW_SHORT_MS 32
`define OWDT_SLOW_LONG_MS 256
`define OWDT_SLOW_SHORT_CNT (`OWDT_SLOW_SHORT_MS * 1000 / `OWDT_SLOW_PERIOD_US)
`define OWDT_SLOW_LONG_CNT (`OWDT_SLOW_LONG_MS * 1000 / `OWDT_SLOW_PERIOD_US)
`define OWDT_BUS_SHORT_CNT 8192
`define OWDT_BUS_LONG_CNT 262144

`endif

// >>> include/owdt_pkg.sv
// types shared by the operating watchdog modules
package owdt_pkg;
	typedef logic [17:0] owdt_count_t;
	typedef logic [2:0] owdt_bits3_t;
	typedef enum logic {OWDT_SRC_SLOW, OWDT_SRC_BUS} owdt_src_e;
endpackage

// >>> include/owdt_cnt_if.sv
// link between the watchdog control logic and its counter
interface owdt_cnt_if;
	logic clear;
	logic tick;
	owdt_pkg::owdt_count_t limit;
	owdt_pkg::owdt_count_t count;
	logic overflow;
	logic half;
	modport ctrl (output clear, output tick, output limit,
		input count, input overflow, input half);
	modport cnt (input clear, input tick, input limit,
		output count, output overflow, output half);
endinterface

// >>> rtl/owdt_counter.sv
// watchdog counter with clear, tick, overflow and half-way pulses
module owdt_counter (
	input wire logic clock_in, // system clock
	input wire logic reset_n_in, // asynchronous reset, active low
	owdt_cnt_if.cnt cnt // control side
);
	owdt_pkg::owdt_count_t count_reg;
	owdt_pkg::owdt_count_t count_next;
	logic overflow_reg;
	logic overflow_next;
	logic half_reg;
	logic half_next;
	logic [18:0] span;
	owdt_pkg::owdt_count_t half_point;

	// a limit of zero stands for the full 2^18 span of the 18-bit counter
	assign span = (cnt.limit == '0) ? 19'h40000 : {1'b0, cnt.limit};
	assign half_point = span[18:1];

	// next count: clear first, then count up and wrap at the limit
	always_comb begin
		count_next = count_reg;
		overflow_next = 1'b0;
		half_next = 1'b0;
		if (cnt.clear) begin
			count_next = '0; // [RQ3] [RQ15]
		end else if (cnt.tick) begin
			if (count_reg == cnt.limit - 18'h00001) begin
				count_next = '0;
				overflow_next = 1'b1; // [RQ7]
			end else begin
				count_next = count_reg + 18'h00001;
				half_next = (count_next == half_point);
			end
		end
	end

	// registers of the counter
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count_reg <= '0;
			overflow_reg <= 1'b0;
			half_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			overflow_reg <= overflow_next;
			half_reg <= half_next;
		end
	end

	assign cnt.count = count_reg;
	assign cnt.overflow = overflow_reg;
	assign cnt.half = half_reg;
endmodule

// >>> rtl/owdt_top.sv
// operating watchdog with an ahb-lite register slave and interrupt
`include "owdt_consts.svh"
module owdt_top #(
	parameter int BUS_SHORT_COUNT = `OWDT_BUS_SHORT_CNT,
	parameter int BUS_LONG_COUNT = `OWDT_BUS_LONG_CNT
) (
	input wire logic clock_in, // 125 mhz bus clock
	input wire logic reset_n_in, // asynchronous reset, active low
	input wire logic hsel_in, // slave select
	input wire logic [31:0] haddr_in, // byte address
	input wire logic [1:0] htrans_in, // transfer type
	input wire logic hwrite_in, // write when high
	input wire logic [2:0] hsize_in, // transfer size
	input wire logic [31:0] hwdata_in, // write data
	input wire logic hready_in, // bus ready
	output logic [31:0] hrdata_out, // read data
	output logic hreadyout_out, // slave ready
	output logic hresp_out, // response, always okay
	input wire logic slow_clock_in, // internal 1 khz clock level
	input wire logic stop_mode_in, // system in stop mode
	input wire logic debug_mode_in, // system in background debug
	input wire logic system_reset_in, // other system reset, one pulse
	output logic watchdog_reset_out, // timeout reset request pulse
	output logic irq_out // interrupt level
);
	localparam owdt_pkg::owdt_count_t SLOW_SHORT =
		18'(`OWDT_SLOW_SHORT_CNT);
	localparam owdt_pkg::owdt_count_t SLOW_LONG =
		18'(`OWDT_SLOW_LONG_CNT);
	localparam owdt_pkg::owdt_count_t BUS_SHORT = 18'(BUS_SHORT_COUNT);
	localparam owdt_pkg::owdt_count_t BUS_LONG = 18'(BUS_LONG_COUNT);

	owdt_cnt_if cnt_bus ();

	// option and lock state
	logic watchdog_enable_reg;
	logic watchdog_enable_next;
	logic watchdog_timeout_select_reg;
	logic watchdog_timeout_select_next;
	owdt_pkg::owdt_src_e watchdog_clock_select_reg;
	owdt_pkg::owdt_src_e watchdog_clock_select_next;
	logic opt1_locked_reg;
	logic opt1_locked_next;
	logic opt2_locked_reg;
	logic opt2_locked_next;

	// cause, interrupt status and mask
	owdt_pkg::owdt_bits3_t reset_cause_register_reg;
	owdt_pkg::owdt_bits3_t reset_cause_register_next;
	owdt_pkg::owdt_bits3_t irq_status_reg;
	owdt_pkg::owdt_bits3_t irq_status_next;
	owdt_pkg::owdt_bits3_t irq_mask_reg;
	owdt_pkg::owdt_bits3_t irq_mask_next;
	logic irq_reg;
	logic irq_next;
	logic watchdog_reset_reg;
	logic watchdog_reset_next;

	// bus slave state
	logic dp_write_reg;
	logic dp_write_next;
	logic [7:0] dp_addr_reg;
	logic [7:0] dp_addr_next;
	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;

	// slow clock synchroniser and edge detect
	logic slow_meta_reg;
	logic slow_sync_reg;
	logic slow_prev_reg;

	// decoded strobes
	logic addr_phase;
	logic wr_cause;
	logic wr_opt1;
	logic wr_opt2;
	logic wr_stat;
	logic wr_mask;
	logic first_opt1;
	logic first_opt2;
	logic refused;
	logic sys_event;
	logic slow_rise;
	logic stop_slow_clear;
	owdt_pkg::owdt_bits3_t events;

	// address phase taken when selected, ready and a word transfer
	assign addr_phase = hsel_in && hready_in && htrans_in[1] &&
		(hsize_in == 3'h2) && (haddr_in[1:0] == 2'h0);

	// data phase write strobes per register
	always_comb begin
		wr_cause = 1'b0;
		wr_opt1 = 1'b0;
		wr_opt2 = 1'b0;
		wr_stat = 1'b0;
		wr_mask = 1'b0;
		if (!dp_write_reg) begin
			wr_cause = 1'b0;
		end else if (dp_addr_reg == `OWDT_OFS_CAUSE) begin
			wr_cause = 1'b1;
		end else if (dp_addr_reg == `OWDT_OFS_OPT1) begin
			wr_opt1 = 1'b1;
		end else if (dp_addr_reg == `OWDT_OFS_OPT2) begin
			wr_opt2 = 1'b1;
		end else if (dp_addr_reg == `OWDT_OFS_STAT) begin
			wr_stat = 1'b1;
		end else if (dp_addr_reg == `OWDT_OFS_MASK) begin
			wr_mask = 1'b1;
		end
	end

	// write-once gating and system reset events
	assign first_opt1 = wr_opt1 && !opt1_locked_reg; // [RQ8]
	assign first_opt2 = wr_opt2 && !opt2_locked_reg; // [RQ8]
	assign refused = (wr_opt1 && opt1_locked_reg) ||
		(wr_opt2 && opt2_locked_reg);
	assign sys_event = cnt_bus.overflow || system_reset_in;
	assign slow_rise = slow_sync_reg && !slow_prev_reg;
	assign stop_slow_clear = stop_mode_in &&
		(watchdog_clock_select_reg == owdt_pkg::OWDT_SRC_SLOW); // [RQ13]

	// counter control: clear sources, tick and limit selection
	always_comb begin
		cnt_bus.clear = wr_cause || // [RQ3]
			first_opt1 || first_opt2 || // [RQ9] [RQ16]
			sys_event || // [RQ15]
			stop_slow_clear; // [RQ13]
		cnt_bus.tick = 1'b0;
		if (watchdog_enable_reg && !debug_mode_in && // [RQ2] [RQ11]
			!stop_mode_in) begin // [RQ12]
			if (watchdog_clock_select_reg == owdt_pkg::OWDT_SRC_BUS) begin
				cnt_bus.tick = 1'b1; // [RQ4]
			end else begin
				cnt_bus.tick = slow_rise; // [RQ4]
			end
		end
		if (watchdog_clock_select_reg == owdt_pkg::OWDT_SRC_BUS) begin
			cnt_bus.limit = watchdog_timeout_select_reg ?
				BUS_LONG : BUS_SHORT; // [RQ5]
		end else begin
			cnt_bus.limit = watchdog_timeout_select_reg ?
				SLOW_LONG : SLOW_SHORT; // [RQ5]
		end
	end

	owdt_counter u_counter (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.cnt(cnt_bus)
	);

	// next values of the options; any system reset restores defaults
	always_comb begin
		watchdog_enable_next = watchdog_enable_reg;
		watchdog_timeout_select_next = watchdog_timeout_select_reg;
		watchdog_clock_select_next = watchdog_clock_select_reg;
		opt1_locked_next = opt1_locked_reg;
		opt2_locked_next = opt2_locked_reg;
		if (sys_event) begin
			watchdog_enable_next = `OWDT_RST_ENABLE; // [RQ1]
			watchdog_timeout_select_next = `OWDT_RST_TSEL; // [RQ6]
			watchdog_clock_select_next =
				owdt_pkg::owdt_src_e'(`OWDT_RST_CSEL); // [RQ6]
			opt1_locked_next = 1'b0;
			opt2_locked_next = 1'b0;
		end else begin
			if (first_opt1) begin
				watchdog_enable_next =
					hwdata_in[`OWDT_OPT1_ENABLE]; // [RQ2]
				watchdog_timeout_select_next =
					hwdata_in[`OWDT_OPT1_TSEL]; // [RQ16]
				opt1_locked_next = 1'b1; // [RQ8]
			end
			if (first_opt2) begin
				watchdog_clock_select_next = owdt_pkg::owdt_src_e'(
					hwdata_in[`OWDT_OPT2_CSEL]); // [RQ16]
				opt2_locked_next = 1'b1; // [RQ8]
			end
		end
	end

	// option registers
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			watchdog_enable_reg <= `OWDT_RST_ENABLE; // [RQ1]
			watchdog_timeout_select_reg <= `OWDT_RST_TSEL; // [RQ6]
			watchdog_clock_select_reg <=
				owdt_pkg::owdt_src_e'(`OWDT_RST_CSEL); // [RQ6]
			opt1_locked_reg <= 1'b0;
			opt2_locked_reg <= 1'b0;
		end else begin
			watchdog_enable_reg <= watchdog_enable_next;
			watchdog_timeout_select_reg <= watchdog_timeout_select_next;
			watchdog_clock_select_reg <= watchdog_clock_select_next;
			opt1_locked_reg <= opt1_locked_next;
			opt2_locked_reg <= opt2_locked_next;
		end
	end

	// interrupt events of this cycle
	always_comb begin
		events = '0;
		events[`OWDT_EV_HALF] = cnt_bus.half;
		events[`OWDT_EV_SERVICE] = wr_cause;
		events[`OWDT_EV_REFUSED] = refused;
	end

	// cause, status, mask, interrupt and timeout pulse next values
	always_comb begin
		reset_cause_register_next = reset_cause_register_reg;
		irq_status_next = irq_status_reg;
		irq_mask_next = irq_mask_reg;
		if (sys_event) begin
			reset_cause_register_next = '0;
			reset_cause_register_next[`OWDT_CAUSE_WDOG] =
				cnt_bus.overflow; // [RQ14]
			reset_cause_register_next[`OWDT_CAUSE_EXT] =
				!cnt_bus.overflow;
			irq_status_next = '0;
			irq_mask_next = '0;
		end else begin
			if (wr_stat) begin
				irq_status_next = irq_status_reg & ~hwdata_in[2:0];
			end
			irq_status_next = irq_status_next | events; // set wins
			if (wr_mask) begin
				irq_mask_next = hwdata_in[2:0];
			end
		end
		irq_next = |(irq_status_next & irq_mask_next);
		watchdog_reset_next = cnt_bus.overflow; // [RQ7] [RQ15]
	end

	// cause, status and output registers
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reset_cause_register_reg <= `OWDT_RST_CAUSE;
			irq_status_reg <= '0;
			irq_mask_reg <= '0;
			irq_reg <= 1'b0;
			watchdog_reset_reg <= 1'b0;
		end else begin
			reset_cause_register_reg <= reset_cause_register_next;
			irq_status_reg <= irq_status_next;
			irq_mask_reg <= irq_mask_next;
			irq_reg <= irq_next;
			watchdog_reset_reg <= watchdog_reset_next;
		end
	end

	// bus address phase capture and read data selection
	always_comb begin
		dp_write_next = addr_phase && hwrite_in;
		dp_addr_next = addr_phase ? haddr_in[7:0] : 8'h00;
		hrdata_next = hrdata_reg;
		if (addr_phase && !hwrite_in) begin
			if (haddr_in[31:8] != 24'h000000) begin
				hrdata_next = 32'h00000000;
			end else if (haddr_in[7:0] == `OWDT_OFS_CAUSE) begin
				hrdata_next = {29'h0, reset_cause_register_reg};
			end else if (haddr_in[7:0] == `OWDT_OFS_OPT1) begin
				hrdata_next = 32'h00000000;
				hrdata_next[`OWDT_OPT1_ENABLE] = watchdog_enable_reg;
				hrdata_next[`OWDT_OPT1_TSEL] =
					watchdog_timeout_select_reg;
			end else if (haddr_in[7:0] == `OWDT_OFS_OPT2) begin
				hrdata_next = 32'h00000000;
				hrdata_next[`OWDT_OPT2_CSEL] =
					watchdog_clock_select_reg;
			end else if (haddr_in[7:0] == `OWDT_OFS_STAT) begin
				hrdata_next = {29'h0, irq_status_reg};
			end else if (haddr_in[7:0] == `OWDT_OFS_MASK) begin
				hrdata_next = {29'h0, irq_mask_reg};
			end else if (haddr_in[7:0] == `OWDT_OFS_COUNT) begin
				hrdata_next = {14'h0, cnt_bus.count};
			end else begin
				hrdata_next = 32'h00000000;
			end
		end
		if (haddr_in[31:8] != 24'h000000) begin
			dp_write_next = 1'b0;
		end
	end

	// bus slave registers
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			dp_write_reg <= 1'b0;
			dp_addr_reg <= 8'h00;
			hrdata_reg <= 32'h00000000;
		end else begin
			dp_write_reg <= dp_write_next;
			dp_addr_reg <= dp_addr_next;
			hrdata_reg <= hrdata_next;
		end
	end

	// synchroniser for the slow clock, then edge detection
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			slow_meta_reg <= 1'b0;
			slow_sync_reg <= 1'b0;
			slow_prev_reg <= 1'b0;
		end else begin
			slow_meta_reg <= slow_clock_in;
			slow_sync_reg <= slow_meta_reg;
			slow_prev_reg <= slow_sync_reg;
		end
	end

	// fixed ready and okay response, held in flip-flops
	logic hready_reg;
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			hready_reg <= 1'b1;
		end else begin
			hready_reg <= 1'b1;
		end
	end
	logic hresp_reg;
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			hresp_reg <= 1'b0;
		end else begin
			hresp_reg <= 1'b0;
		end
	end

	// outputs straight from flip-flops
	assign hrdata_out = hrdata_reg;
	assign hreadyout_out = hready_reg;
	assign hresp_out = hresp_reg;
	assign watchdog_reset_out = watchdog_reset_reg;
	assign irq_out = irq_reg;
endmodule

// >>> test/owdt_top_asserts.sv
// port assertions for the operating watchdog
module owdt_top_asserts #(
	parameter int BUS_SHORT_COUNT = 16,
	parameter int BUS_LONG_COUNT = 64
) (
	input wire logic clock_in, // clock
	input wire logic reset_n_in, // reset
	input wire logic hsel_in, // select
	input wire logic [31:0] haddr_in, // address
	input wire logic [1:0] htrans_in, // transfer
	input wire logic hwrite_in, // direction
	input wire logic [2:0] hsize_in, // size
	input wire logic hready_in, // ready
	input wire logic [31:0] hrdata_out, // read data
	input wire logic hreadyout_out, // slave ready
	input wire logic hresp_out, // response
	input wire logic stop_mode_in, // stop
	input wire logic debug_mode_in, // debug
	input wire logic system_reset_in, // other reset
	input wire logic watchdog_reset_out, // timeout pulse
	input wire logic irq_out // interrupt
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);
	logic req;
	logic svc;
	int since;
	// word transfers, and word writes at the cause address
	assign req = hsel_in && hready_in && htrans_in[1] && hsize_in == 3'h2;
	assign svc = req && hwrite_in && haddr_in == 32'h0;
	// cycles since the last service or reset
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in)
			since <= 0;
		else if (svc || system_reset_in || watchdog_reset_out)
			since <= 0;
		else if (since < BUS_LONG_COUNT)
			since <= since + 1;
	end
	ready_okay_a: assert property (hreadyout_out && !hresp_out)
		else $error("slave not ready or not okay");
	wd_pulse_a: assert property (watchdog_reset_out |=>
		!watchdog_reset_out [*8]) else $error("timeout pulse too long");
	svc_quiet_a: assert property (svc |-> ##4
		!watchdog_reset_out [*8]) else $error("reset after service");
	dbg_hold_a: assert property (debug_mode_in [*4]
		|-> !watchdog_reset_out) else $error("reset in debug");
	stop_hold_a: assert property (stop_mode_in [*4]
		|-> !watchdog_reset_out) else $error("reset in stop");
	sysrst_irq_a: assert property (system_reset_in |-> ##2
		!irq_out) else $error("irq after system reset");
	cause_hot_a: assert property (req && !hwrite_in &&
		haddr_in == 32'h0 |=> $onehot(hrdata_out[2:0]) &&
		hrdata_out[31:3] == 29'h0) else $error("bad cause value");
	min_timeout_a: assert property (watchdog_reset_out |->
		since < 4 || since >= BUS_SHORT_COUNT)
		else $error("timeout too early");
	cover property (svc);
	cover property (watchdog_reset_out);
	cover property (debug_mode_in [*4]);
	cover property (stop_mode_in [*4]);
endmodule
bind owdt_top owdt_top_asserts #(.BUS_SHORT_COUNT(BUS_SHORT_COUNT),
	.BUS_LONG_COUNT(BUS_LONG_COUNT)) u_chk (.*);

// >>> test/owdt_host.sv
// ahb-lite master standing in for application software
module owdt_host (
	input wire logic clock_in, // bus clock
	input wire logic hready_in, // bus ready
	input wire logic [31:0] hrdata_in, // read data
	output logic hsel_out, // select
	output logic [31:0] haddr_out, // address
	output logic [1:0] htrans_out, // transfer type
	output logic hwrite_out, // direction
	output logic [2:0] hsize_out, // size
	output logic [31:0] hwdata_out // write data
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus from time zero
	initial begin
		hsel_out = 1'h0;
		haddr_out = 32'h0;
		htrans_out = 2'h0;
		hwrite_out = 1'h0;
		hsize_out = 3'h2;
		hwdata_out = 32'h0;
	end
	// one word; service writes come from main code only
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clock_in);
		hsel_out <= 1'h1;
		haddr_out <= {24'h0, a};
		htrans_out <= 2'h2;
		hwrite_out <= w;
		do @(posedge clock_in); while (hready_in !== 1'h1);
		hsel_out <= 1'h0;
		htrans_out <= 2'h0;
		hwdata_out <= d;
		do @(posedge clock_in); while (hready_in !== 1'h1);
		r = hrdata_in;
		hwdata_out <= ~d; // released data shows no stale value
	endtask
endmodule

// >>> test/tb_operating_watchdog_timer.sv
// self-checking bench for the operating watchdog
module tb_operating_watchdog_timer;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SLOW = 16; // clocks per slow tick
	logic clock = 1'h0;
	logic rst_n = 1'h0;
	logic stop = 1'h0;
	logic dbg = 1'h0;
	logic sysrst = 1'h0;
	logic [3:0] sc = 4'h0;
	logic hsel, hwrite, hready, hresp, wd, irq;
	logic [31:0] haddr, hwdata, hrdata, a, b;
	logic [1:0] htrans;
	logic [2:0] hsize;
	int err_total = 0;
	int compares = 0;
	int pulses = 0;
	int seed, n, p0, m1, m2, mc, ms, mk;
	bit k1, k2;
	owdt_host host (.clock_in(clock), .hready_in(hready),
		.hrdata_in(hrdata), .hsel_out(hsel), .haddr_out(haddr),
		.htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
		.hwdata_out(hwdata));
	owdt_top #(.BUS_SHORT_COUNT(16), .BUS_LONG_COUNT(64)) dut (
		.clock_in(clock), .reset_n_in(rst_n), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
		.hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.slow_clock_in(sc[3]), .stop_mode_in(stop),
		.debug_mode_in(dbg), .system_reset_in(sysrst),
		.watchdog_reset_out(wd), .irq_out(irq));
	// clock and slow source
	initial begin
		forever #4 clock = ~clock;
	end
	always @(posedge clock) begin
		sc <= sc + 4'h1;
		if (wd === 1'h1)
			pulses++;
	end
	task automatic give_verdict;
		$display("compares %0d, err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge clock);
	endtask
	// model state after a reset of the given cause
	task automatic mrst(input int c);
		m1 = 3;
		m2 = 0;
		k1 = 0;
		k2 = 0;
		ms = 0;
		mk = 0;
		mc = c;
	endtask
	function automatic logic [31:0] mv(input logic [7:0] ad);
		case (ad)
		8'h00: return mc;
		8'h04: return m1;
		8'h08: return m2;
		8'h0c: return ms;
		8'h10: return mk;
		default: return 0;
		endcase
	endfunction
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] r;
		host.xfer(ad, 1'h1, d, r);
		case (ad)
		8'h00: ms |= 2;
		8'h04: if (k1) ms |= 4; else begin m1 = d & 3; k1 = 1; end
		8'h08: if (k2) ms |= 4; else begin m2 = d & 1; k2 = 1; end
		8'h0c: ms &= ~int'(d);
		8'h10: mk = d & 7;
		default: ;
		endcase
	endtask
	task automatic rc(input logic [7:0] ad, input logic [31:0] m);
		logic [31:0] r;
		host.xfer(ad, 1'h0, 32'h0, r);
		chk(r & m, mv(ad) & m);
	endtask
	task automatic wait_wd(output int c);
		c = 0;
		do begin @(posedge clock); c++; end while (wd !== 1'h1 && c < 9000);
		chk(c < 9000, 1'h1);
		mrst(2);
	endtask
	// watchdog against a hang
	initial begin
		tick(30000);
		err_total++;
		give_verdict();
	end
	// main sequence
	initial begin
		seed = 75;
		tick(16);
		rst_n <= 1'h1;
		mrst(1);
		rc(8'h00, 32'hffffffff);
		rc(8'h04, 32'hffffffff);
		rc(8'h08, 32'hffffffff);
		rc(8'h20, 32'hffffffff);
		wait_wd(n);
		chk(n > 254 * SLOW && n < 257 * SLOW, 1'h1);
		rc(8'h00, 32'hffffffff);
		rc(8'h04, 32'hffffffff);
		tick(200);
		wr(8'h04, 32'h1);
		wait_wd(n);
		chk(n > 31 * SLOW - 4 && n < 33 * SLOW, 1'h1);
		wr(8'h08, 32'h1);
		wr(8'h04, 32'h3);
		wr(8'h04, 32'h0);
		rc(8'h04, 32'hffffffff);
		wr(8'h10, 32'h4);
		tick(2);
		chk(irq, 1'h1);
		wr(8'h0c, 32'h4);
		tick(2);
		chk(irq, 1'h0);
		p0 = pulses;
		repeat (20) begin
			wr(8'h00, $random(seed));
			tick($random(seed) & 15);
		end
		chk(pulses, p0);
		rc(8'h00, 32'hffffffff);
		rc(8'h0c, 32'h6);
		stop <= 1'h1;
		tick(2);
		host.xfer(8'h14, 1'h0, 32'h0, a);
		tick(40);
		host.xfer(8'h14, 1'h0, 32'h0, b);
		chk(b, a);
		stop <= 1'h0;
		tick(4);
		host.xfer(8'h14, 1'h0, 32'h0, b);
		chk(b, a + 32'h5);
		dbg <= 1'h1;
		tick(2);
		host.xfer(8'h14, 1'h0, 32'h0, a);
		tick(40);
		host.xfer(8'h14, 1'h0, 32'h0, b);
		chk(b, a);
		dbg <= 1'h0;
		wait_wd(n);
		chk(n >= 62 - a && n <= 68 - a, 1'h1);
		wr(8'h04, 32'h1);
		tick(20 * SLOW);
		stop <= 1'h1;
		tick(8);
		stop <= 1'h0;
		host.xfer(8'h14, 1'h0, 32'h0, a);
		chk(a < 2, 1'h1);
		wait_wd(n);
		chk(n > 30 * SLOW, 1'h1);
		wr(8'h04, 32'h0);
		p0 = pulses;
		tick(300 * SLOW);
		chk(pulses, p0);
		rc(8'h04, 32'hffffffff);
		sysrst <= 1'h1;
		tick(1);
		sysrst <= 1'h0;
		mrst(4);
		rc(8'h00, 32'hffffffff);
		rc(8'h04, 32'hffffffff);
		wr(8'h04, 32'h1);
		rc(8'h04, 32'hffffffff);
		// bus clock with the short count: half-way flag, then timeout
		wr(8'h08, 32'h1);
		tick(8);
		ms |= 1;
		rc(8'h0c, 32'h1);
		wait_wd(n);
		chk(n, 7);
		rst_n <= 1'h0;
		tick(16);
		rst_n <= 1'h1;
		mrst(1);
		rc(8'h00, 32'hffffffff);
		rc(8'h04, 32'hffffffff);
		give_verdict();
	end
endmodule
